// File: core/data_memory_defines.vh
`ifndef DATA_MEMORY_DEFINES_VH
`define DATA_MEMORY_DEFINES_VH

`define DM_ADDR_W          7
`define PM_ADDR_W          10
`define PM_WORD_W          14
`define PM_HIGH_W          6
`define PM_PAGE_MASK       10'h300
`define PM_LAST_PAGE       10'h300
`define SFR_BANK_POINTER   7'h04
`define SFR_TABLE_POINTER  7'h07
`define SFR_TABLE_HIGH     7'h08
`define GP_BASE            7'h40
`define EEPROM_CONTROL     7'h40
`define BANK_POINTER_RST   8'h00
`define TABLE_POINTER_RST  8'h00
`define TABLE_HIGH_RST     8'h00
`define EEPROM_CONTROL_RST 8'h00
`define EEPROM_CONTROL_WM  8'h0F
`define ZERO_BYTE          8'h00
`define TABLE_CYCLES       2'h2

`endif

// File: core/data_memory_bank.v
`timescale 1ns/1ps
`include "data_memory_defines.vh"

module data_memory_bank (
  input  wire                      clock,
  input  wire                      reset,
  input  wire [`DM_ADDR_W-1:0]     dm_addr,
  input  wire                      dm_wr,
  input  wire [7:0]                dm_wdata,
  input  wire                      dm_bit_op,
  input  wire [2:0]                dm_bit_sel,
  input  wire                      dm_bit_val,
  output reg  [7:0]                dm_rdata,
  input  wire                      table_read_current_page,
  input  wire                      table_read_last_page,
  input  wire [`DM_ADDR_W-1:0]     table_dest_addr,
  input  wire [`PM_ADDR_W-1:0]     exec_pc,
  output reg  [`PM_ADDR_W-1:0]     pm_addr,
  input  wire [`PM_WORD_W-1:0]     pm_data,
  output wire                      table_busy,
  output wire                      table_done,
  output wire [7:0]                bank_pointer,
  output wire [7:0]                eeprom_control,
  input  wire                      emulation_mode,
  input  wire                      prog_mode,
  input  wire                      prog_serial_data_in,
  output wire                      prog_serial_data_out,
  output wire                      prog_serial_data_oe,
  input  wire                      prog_serial_clock,
  input  wire                      prog_data_out,
  input  wire                      prog_data_oe,
  output wire                      prog_data_in,
  output wire                      prog_clock,
  input  wire                      debug_data_addr_pin_in,
  output wire                      debug_data_addr_pin_out,
  output wire                      debug_data_addr_pin_oe,
  input  wire                      debug_clock_pin,
  input  wire                      debug_data_out,
  input  wire                      debug_data_oe,
  output wire                      debug_data_in,
  output wire                      debug_clock,
  input  wire                      func_pin_out,
  input  wire                      func_pin_oe,
  input  wire                      func_clock_pin_out,
  input  wire                      func_clock_pin_oe,
  output wire                      func_pin_in,
  output wire                      func_clock_pin_in,
  output wire                      clock_pin_oe,
  output wire                      clock_pin_out
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_FETCH = 1'b1;

  reg [7:0]                ram_bank0 [0:63];
  reg [7:0]                ram_bank1 [0:63];
  reg [7:0]                bank_pointer_r;
  reg [7:0]                table_pointer_r;
  reg [7:0]                table_high_r;
  reg [7:0]                eeprom_control_r;
  reg                      state_r;
  reg                      state_nxt;
  reg [1:0]                cycle_r;
  reg [`DM_ADDR_W-1:0]     dest_r;
  reg [7:0]                wr_byte;
  reg [`DM_ADDR_W-1:0]     wr_addr;
  reg                      wr_en;
  reg [7:0]                cur_byte;
  reg                      serial_data_out;
  reg                      serial_data_oe;
  reg                      dbg_data_in;
  reg                      dbg_clock;
  reg                      user_pin_in;
  reg                      user_clock_in;
  reg                      user_clock_oe;
  wire                     take_start;
  wire                     wr_ram;

  function is_gp;
    input [`DM_ADDR_W-1:0] a;
    begin
      is_gp = (a >= `GP_BASE);
    end
  endfunction

  function is_ctrl;
    input [`DM_ADDR_W-1:0] a;
    input                  bank1;
    begin
      is_ctrl = bank1 && (a == `EEPROM_CONTROL);
    end
  endfunction

  function [7:0] gp_read;
    input [`DM_ADDR_W-1:0] a;
    input                  bank1;
    begin
      if (bank1)
        gp_read = ram_bank1[a[5:0]];
      else
        gp_read = ram_bank0[a[5:0]];
    end
  endfunction

  function [7:0] read_loc;
    input [`DM_ADDR_W-1:0] a;
    begin
      read_loc = `ZERO_BYTE;
      if (is_ctrl(a, bank_pointer_r[0])) begin
        read_loc = eeprom_control_r;
      end else if (is_gp(a)) begin
        read_loc = gp_read(a, bank_pointer_r[0]);
      end else begin
        case (a)
          `SFR_BANK_POINTER:  read_loc = bank_pointer_r;
          `SFR_TABLE_POINTER: read_loc = table_pointer_r;
          `SFR_TABLE_HIGH:    read_loc = table_high_r;
          default:            read_loc = `ZERO_BYTE;
        endcase
      end
    end
  endfunction

  // program address of a table read
  function [`PM_ADDR_W-1:0] table_addr;
    input                  last;
    input [`PM_ADDR_W-1:0] pc;
    input [7:0]            ptr;
    begin
      if (last)
        table_addr = `PM_LAST_PAGE | {2'b00, ptr};
      else
        table_addr = (pc & `PM_PAGE_MASK) | {2'b00, ptr};
    end
  endfunction

  assign bank_pointer   = bank_pointer_r;
  assign eeprom_control = eeprom_control_r;
  assign table_busy     = (state_r == ST_FETCH);
  assign table_done     = (state_r == ST_FETCH) && (cycle_r == `TABLE_CYCLES - 2'h1);

  // table sequencer: cycle 0 forms address, cycle 1 returns word
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (table_read_current_page || table_read_last_page)
          state_nxt = ST_FETCH;
      end
      ST_FETCH: begin
        if (cycle_r == `TABLE_CYCLES - 2'h1)
          state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  assign take_start = (state_r == ST_IDLE) && (state_nxt == ST_FETCH);

  always @(posedge clock) begin
    if (reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // cycle count inside the two-cycle read
  always @(posedge clock) begin
    if (reset) begin
      cycle_r <= 2'h0;
    end else if (take_start) begin
      cycle_r <= 2'h1;
    end else begin
      cycle_r <= 2'h0;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      dest_r <= {`DM_ADDR_W{1'b0}};
    end else if (take_start) begin
      dest_r <= table_dest_addr;
    end
  end

  // address formed once, on the accepted start edge
  always @(posedge clock) begin
    if (reset) begin
      pm_addr <= {`PM_ADDR_W{1'b0}};
    end else if (take_start) begin
      pm_addr <= table_addr(table_read_last_page, exec_pc, table_pointer_r);
    end
  end

  // data write path: table result wins over a concurrent program write
  always @* begin
    wr_en    = 1'b0;
    wr_addr  = dm_addr;
    wr_byte  = dm_wdata;
    cur_byte = read_loc(dm_addr);
    if (table_done) begin
      wr_en   = 1'b1;
      wr_addr = dest_r;
      wr_byte = pm_data[7:0];
    end else if (dm_wr) begin
      wr_en = 1'b1;
      if (dm_bit_op) begin
        wr_byte = cur_byte;
        wr_byte[dm_bit_sel] = dm_bit_val;
      end
    end
  end

  assign wr_ram = wr_en && is_gp(wr_addr) && !is_ctrl(wr_addr, bank_pointer_r[0]);

  // one array per bank; the bank pointer steers the write
  always @(posedge clock) begin
    if (wr_ram && bank_pointer_r[0]) begin
      ram_bank1[wr_addr[5:0]] <= wr_byte;
    end
  end

  always @(posedge clock) begin
    if (wr_ram && !bank_pointer_r[0]) begin
      ram_bank0[wr_addr[5:0]] <= wr_byte;
    end
  end

  // read data, one cycle after the address
  always @(posedge clock) begin
    if (reset) begin
      dm_rdata <= `ZERO_BYTE;
    end else begin
      dm_rdata <= read_loc(dm_addr);
    end
  end

  // loaded only by a finished table read; no software write path
  always @(posedge clock) begin
    if (reset) begin
      table_high_r <= `TABLE_HIGH_RST;
    end else if (table_done) begin
      table_high_r <= {{(8-`PM_HIGH_W){1'b0}}, pm_data[`PM_WORD_W-1:8]};
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      bank_pointer_r <= `BANK_POINTER_RST;
    end else if (wr_en && (wr_addr == `SFR_BANK_POINTER)) begin
      bank_pointer_r <= {7'h00, wr_byte[0]};
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      table_pointer_r <= `TABLE_POINTER_RST;
    end else if (wr_en && (wr_addr == `SFR_TABLE_POINTER)) begin
      table_pointer_r <= wr_byte;
    end
  end

  // only the low nibble is writable
  always @(posedge clock) begin
    if (reset) begin
      eeprom_control_r <= `EEPROM_CONTROL_RST;
    end else if (wr_en && is_ctrl(wr_addr, bank_pointer_r[0])) begin
      eeprom_control_r <= wr_byte & `EEPROM_CONTROL_WM;
    end
  end

  // pin sharing: programming always live, debug inputs only in emulation, debug_data_out drives pin data outside prog mode,
  // shared user functions silenced in both
  always @* begin
    serial_data_out = debug_data_out;
    serial_data_oe  = func_pin_oe;
    dbg_data_in     = 1'b0;
    dbg_clock       = 1'b0;
    user_pin_in     = prog_serial_data_in;
    user_clock_in   = prog_serial_clock;
    user_clock_oe   = func_clock_pin_oe;
    if (prog_mode) begin
      serial_data_out = prog_data_out;
      serial_data_oe  = prog_data_oe;
      user_pin_in     = 1'b0;
      user_clock_in   = 1'b0;
      user_clock_oe   = 1'b0;
    end else if (emulation_mode) begin
      serial_data_oe  = debug_data_oe;
      user_pin_in     = 1'b0;
      user_clock_in   = 1'b0;
      user_clock_oe   = 1'b0;
    end
    if (emulation_mode) begin
      dbg_data_in = debug_data_addr_pin_in;
      dbg_clock   = debug_clock_pin;
    end
  end

  assign prog_serial_data_out    = serial_data_out;
  assign prog_serial_data_oe     = serial_data_oe;
  assign debug_data_addr_pin_out = serial_data_out;
  // same physical pin as the programming data pin, enabled through it
  assign debug_data_addr_pin_oe  = 1'b0;
  assign prog_data_in            = prog_serial_data_in;
  assign prog_clock              = prog_serial_clock;
  assign debug_data_in           = dbg_data_in;
  assign debug_clock             = dbg_clock;
  assign func_pin_in             = user_pin_in;
  assign func_clock_pin_in       = user_clock_in;
  assign clock_pin_oe            = user_clock_oe;
  assign clock_pin_out           = func_clock_pin_out;

endmodule

// File: dv/prog_memory_model.sv
`timescale 1ns/1ps
module prog_memory_model (
  input  wire [9:0]  pm_addr,
  output wire [13:0] pm_data
);
  // address-derived word, high part distinct per page
  assign pm_data = {pm_addr[9:4], pm_addr[7:0] ^ 8'h5A};
endmodule

// File: dv/dmb_checker.sv
`timescale 1ns/1ps
module dmb_checker (
  input wire       clock,
  input wire       reset,
  input wire       table_read_current_page,
  input wire       table_read_last_page,
  input wire [9:0] exec_pc,
  input wire [9:0] pm_addr,
  input wire       table_busy,
  input wire       table_done,
  input wire [7:0] bank_pointer,
  input wire [7:0] eeprom_control,
  input wire       debug_data_addr_pin_oe
);
  wire       start   = table_read_current_page | table_read_last_page;
  wire [1:0] pc_page = exec_pc[9:8];
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  chk_done_after_start: assert property (!table_busy && start |=> table_done && table_busy)
    else $error("table read did not finish in two cycles");
  chk_done_one_cycle: assert property (table_done |=> !table_done && !table_busy)
    else $error("table done or busy lasted too long");
  chk_last_page_base: assert property (!table_busy && table_read_last_page |=> pm_addr[9:8] == 2'h3)
    else $error("last page read outside final page");
  chk_cur_page_base: assert property (!table_busy && table_read_current_page && !table_read_last_page
    |=> pm_addr[9:8] == $past(pc_page))
    else $error("current page read left executing page");
  chk_busy_cause: assert property ($rose(table_busy) |-> $past(start))
    else $error("busy rose without a start");
  chk_bank_bits: assert property (bank_pointer[7:1] == 7'h00)
    else $error("bank pointer upper bits set");
  chk_eec_mask: assert property (eeprom_control[7:4] == 4'h0)
    else $error("eeprom control upper bits set");
  chk_debug_oe_off: assert property (debug_data_addr_pin_oe == 1'h0)
    else $error("debug pin enable driven");
endmodule
bind data_memory_bank dmb_checker chk (.clock(clock), .reset(reset),
  .table_read_current_page(table_read_current_page), .table_read_last_page(table_read_last_page),
  .exec_pc(exec_pc), .pm_addr(pm_addr), .table_busy(table_busy), .table_done(table_done),
  .bank_pointer(bank_pointer), .eeprom_control(eeprom_control),
  .debug_data_addr_pin_oe(debug_data_addr_pin_oe));

// File: dv/test_data_memory_bank.sv
`timescale 1ns/1ps
module test_data_memory_bank;
  logic clock = 0, reset = 1, dm_wr = 0, dm_bit_op = 0, dm_bit_val = 0, rdc = 0, rdl = 0;
  logic [6:0] dm_addr = 7'h00, dest = 7'h00;
  logic [7:0] dm_wdata = 8'h00, dm_rdata, bank_pointer, eeprom_control;
  logic [2:0] dm_bit_sel = 3'h0;
  logic [9:0] exec_pc = 10'h000, pm_addr;
  logic [13:0] pins = 14'h0000, pm_data;
  logic table_busy, table_done, ps_oe, pclk, fpin, dclk;
  int error_cnt = 0, compares = 0;
  always #5 clock = ~clock;
  prog_memory_model pm (.pm_addr(pm_addr), .pm_data(pm_data));
  data_memory_bank uut (.clock(clock), .reset(reset), .dm_addr(dm_addr), .dm_wr(dm_wr),
    .dm_wdata(dm_wdata), .dm_bit_op(dm_bit_op), .dm_bit_sel(dm_bit_sel), .dm_bit_val(dm_bit_val),
    .dm_rdata(dm_rdata), .table_read_current_page(rdc), .table_read_last_page(rdl),
    .table_dest_addr(dest), .exec_pc(exec_pc), .pm_addr(pm_addr), .pm_data(pm_data),
    .table_busy(table_busy), .table_done(table_done), .bank_pointer(bank_pointer),
    .eeprom_control(eeprom_control), .emulation_mode(pins[0]), .prog_mode(pins[1]),
    .prog_serial_data_in(pins[2]), .prog_serial_data_out(), .prog_serial_data_oe(ps_oe),
    .prog_serial_clock(pins[3]), .prog_data_out(pins[4]), .prog_data_oe(pins[5]),
    .prog_data_in(), .prog_clock(pclk), .debug_data_addr_pin_in(pins[6]),
    .debug_data_addr_pin_out(), .debug_data_addr_pin_oe(), .debug_clock_pin(pins[7]),
    .debug_data_out(pins[8]), .debug_data_oe(pins[9]), .debug_data_in(), .debug_clock(dclk),
    .func_pin_out(pins[10]), .func_pin_oe(pins[11]), .func_clock_pin_out(pins[12]),
    .func_clock_pin_oe(pins[13]), .func_pin_in(fpin), .func_clock_pin_in(), .clock_pin_oe(),
    .clock_pin_out());
  task automatic give_verdict();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic b = 0,
                    input logic [2:0] s = 3'h0);
    @(negedge clock);
    {dm_addr, dm_wdata, dm_bit_op, dm_bit_sel, dm_bit_val, dm_wr} = {a, d, b, s, d[0], 1'b1};
    @(negedge clock);
    {dm_wr, dm_bit_op} = 2'b00;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(negedge clock);
    dm_addr = a;
    @(negedge clock);
    chk(dm_rdata, e);
  endtask
  // one read at a time, never nested
  task automatic tbl(input logic last, input logic [9:0] pc, input logic [6:0] dst);
    int n;
    @(negedge clock);
    {exec_pc, dest, rdl, rdc} = {pc, dst, last, !last};
    @(negedge clock);
    {rdl, rdc} = 2'b00;
    for (n = 0; n < 4 && table_done !== 1'b1; n++) @(negedge clock);
    if (n == 4) begin
      error_cnt++;
      give_verdict();
    end
    @(negedge clock);
  endtask
  task automatic t_mem();
    wr(7'h41, 8'hA5); wr(7'h7F, 8'h3C); wr(7'h40, 8'hC3);
    wr(7'h04, 8'h01); wr(7'h41, 8'h5A);
    rd(7'h41, 8'h5A);
    wr(7'h04, 8'h00);
    rd(7'h41, 8'hA5);
    rd(7'h7F, 8'h3C);
    rd(7'h40, 8'hC3);
    $display("test mem done");
  endtask
  task automatic t_sfr();
    wr(7'h04, 8'hFF);
    rd(7'h04, 8'h01);
    wr(7'h40, 8'hFF);
    rd(7'h40, 8'h0F);
    wr(7'h04, 8'h00);
    rd(7'h40, 8'hC3);
    wr(7'h20, 8'h77);
    rd(7'h20, 8'h00);
    wr(7'h45, 8'h00); wr(7'h45, 8'h01, 1, 3'h3);
    rd(7'h45, 8'h08);
    wr(7'h45, 8'hFF); wr(7'h45, 8'h00, 1, 3'h3);
    rd(7'h45, 8'hF7);
    $display("test sfr done");
  endtask
  task automatic t_tbl();
    wr(7'h07, 8'h06); tbl(1, 10'h0F0, 7'h50);
    rd(7'h50, 8'h5C);
    rd(7'h08, 8'h30);
    wr(7'h08, 8'hFF);
    rd(7'h08, 8'h30);
    wr(7'h07, 8'h07); tbl(0, 10'h1F3, 7'h51);
    rd(7'h51, 8'h5D);
    rd(7'h08, 8'h10);
    wr(7'h46, 8'h99); wr(7'h07, 8'h00);
    rd(7'h08, 8'h10);
    @(negedge clock);
    pins = 14'h003A;
    @(negedge clock);
    chk({6'h00, ps_oe, pclk}, 8'h03);
    pins = 14'h0085;
    @(negedge clock);
    chk({6'h00, fpin, dclk}, 8'h01);
    pins = 14'h0004;
    @(negedge clock);
    chk({6'h00, fpin, dclk}, 8'h02);
    $display("test tbl done");
  endtask
  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    reset = 0;
    t_mem();
    t_sfr();
    t_tbl();
    give_verdict();
  end
endmodule
